// ===== rtl/dcd_cfg.svh
// constants for the counter / digital io / status block
// assumes: included by the modules by bare name
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH
// register byte offsets (byte address = offset * 4 on apb)
`define DCD_OFS_STATUS   6'h07
`define DCD_OFS_PORT_A   6'h08
`define DCD_OFS_PORT_B   6'h09
`define DCD_OFS_PORT_C   6'h0A
`define DCD_OFS_DIO_CTL  6'h0B
`define DCD_OFS_CNT_LO   6'h0C
`define DCD_OFS_CNT_MID  6'h0D
`define DCD_OFS_CNT_HI   6'h0E
`define DCD_OFS_CMD      6'h0F
`define DCD_OFS_REV      6'h10
`define DCD_OFS_CNT_CTL  6'h11
// digital io control fields
`define DCD_BIT_PIN_SEL  7
`define DCD_BIT_DIR_A    4
`define DCD_BIT_DIR_CH   3
`define DCD_BIT_DIR_B    1
`define DCD_BIT_DIR_CL   0
`define DCD_DIO_CTL_RST  8'h9B
// counter command fields
`define DCD_BIT_SEL      7
`define DCD_BIT_LATCH    6
`define DCD_BIT_GT_DIS   5
`define DCD_BIT_GT_EN    4
`define DCD_BIT_CT_DIS   3
`define DCD_BIT_CT_EN    2
`define DCD_BIT_LOAD     1
`define DCD_BIT_ZERO     0
// counter clock control fields
`define DCD_BIT_C1_SRC   7
`define DCD_BIT_C1_RATE  6
`define DCD_BIT_C0_RATE  5
// rates: 200 MHz system clock
`define DCD_CLK_HZ       200000000
`define DCD_DIV_10M      (`DCD_CLK_HZ / 10000000)
`define DCD_DIV_1M       (`DCD_CLK_HZ / 1000000)
`define DCD_DIV_100K     (`DCD_CLK_HZ / 100000)
`endif

// ===== rtl/dcd_pkg.sv
// types for the counter / digital io / status block
// assumes: nothing beyond the cfg header
package dcd_pkg;
	typedef logic [7:0]  dcd_byte_t;
	typedef logic [23:0] dcd_cnt_t;
	typedef enum logic { DCD_SRC_INT, DCD_SRC_EXT } dcd_src_e;
endpackage : dcd_pkg

// ===== rtl/dcd_rate_gen.sv
// rate generator: one-cycle enables at 10 MHz, 1 MHz and 100 kHz
// assumes: single system clock, synchronous reset
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_rate_gen
	import dcd_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      en_10m_o,
	output logic      en_1m_o,
	output logic      en_100k_o
);
	logic [4:0]  div10_q;
	logic [3:0]  div1_q;
	logic [6:0]  div100_q;

	// cascaded so all three enables stay phase aligned
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div10_q   <= 5'h0;
			div1_q    <= 4'h0;
			div100_q  <= 7'h0;
			en_10m_o  <= 1'b0;
			en_1m_o   <= 1'b0;
			en_100k_o <= 1'b0;
		end else begin
			en_10m_o  <= 1'b0;
			en_1m_o   <= 1'b0;
			en_100k_o <= 1'b0;
			if (div10_q == 5'(`DCD_DIV_10M - 1)) begin
				div10_q  <= 5'h0;
				en_10m_o <= 1'b1;
				if (div1_q == 4'(`DCD_DIV_1M / `DCD_DIV_10M - 1)) begin
					div1_q  <= 4'h0;
					en_1m_o <= 1'b1;
				end else begin
					div1_q <= div1_q + 4'h1;
				end
				if (div100_q == 7'(`DCD_DIV_100K / `DCD_DIV_10M - 1)) begin
					div100_q  <= 7'h0;
					en_100k_o <= 1'b1;
				end else begin
					div100_q <= div100_q + 7'h1;
				end
			end else begin
				div10_q <= div10_q + 5'h1;
			end
		end
	end
endmodule : dcd_rate_gen

// ===== rtl/dcd_down_counter.sv
// one down-counter with load, zero, count enable and gate enable
// assumes: commands arrive as one-cycle pulses, tick is a one-cycle enable
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_down_counter
	import dcd_pkg::*;
#(
	parameter int W = 24
)(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         tick_i,
	input  wire logic         gate_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] load_val_i,
	input  wire logic         zero_i,
	input  wire logic         ct_en_i,
	input  wire logic         ct_dis_i,
	input  wire logic         gt_en_i,
	input  wire logic         gt_dis_i,
	output logic [W-1:0]      count_o,
	output logic              out_o
);
	logic run_q;
	logic gated_q;
	logic step;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= 1'b0;
		end else if (ct_en_i) begin
			run_q <= 1'b1;
		end else if (ct_dis_i) begin
			run_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gated_q <= 1'b0;
		end else if (gt_en_i) begin
			gated_q <= 1'b1;
		end else if (gt_dis_i) begin
			gated_q <= 1'b0;
		end
	end

	// gate low pauses only while gating is on
	assign step = tick_i && run_q && (!gated_q || gate_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= '0;
		end else if (load_i) begin
			count_o <= load_val_i;
		end else if (zero_i) begin
			count_o <= '0;
		end else if (step) begin
			count_o <= count_o - W'(1);
		end
	end

	// terminal pulse: one cycle when a step reaches zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_o <= 1'b0;
		end else begin
			out_o <= step && (count_o == W'(1));
		end
	end
endmodule : dcd_down_counter

// ===== rtl/dcd_top.sv
// counter, digital io and status block behind an apb slave
// assumes: apb master on SYS_CLK_I; pins and status sources are asynchronous
//
// Function
// - status upper nibble shows dma, timer, digital io, analog pending flags
// - status low nibble shows the current analog channel
// - ports a, b, c read and write at consecutive offsets
// - direction bits: 0 makes lines outputs, 1 makes them inputs
// - pin select 0 puts gate 0, gate 1, clock 1, out 0 on c4..c7
// - pin select 1: c7..c4 follow upper c direction; else fixed directions
// - pin select resets to 1
// - counter byte writes only fill staging; load command moves them
// - counter byte reads return latched value, not staged bytes
// - counter 0 is 24 bits, counter 1 is 16 bits
// - loading counter 1 ignores the staged high byte
// - bit 7 picks counter; each set bit of 6..0 picks an operation, several may act at once
// - latch copies selected counter into readback bytes
// - latching counter 1 keeps the high readback byte
// - gating enable makes counting follow the gate; disable removes it
// - count enable decrements on each input pulse
// - count disable ignores input pulses
// - load copies staged bytes into the selected counter
// - clear sets the selected counter to zero
// - staged bytes may be written in any order
// - revision register shows major and minor nibbles
// - counter 0 input is 10 MHz or 1 MHz by rate select
// - counter 1 input is internal 10 MHz/100 kHz or the external pin
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_top
	import dcd_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h13 // arbitrary value
)(
	input  wire logic        SYS_CLK_I,
	input  wire logic        SRST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic [3:0]  PSTRB_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        DMA_PENDING_FLAG_I,
	input  wire logic        TIMER_PENDING_FLAG_I,
	input  wire logic        DIGITAL_IO_PENDING_FLAG_I,
	input  wire logic        ANALOG_PENDING_FLAG_I,
	input  wire logic [3:0]  CURRENT_ANALOG_CHANNEL_I,
	input  wire logic [7:0]  PORT_A_I,
	output logic      [7:0]  PORT_A_O,
	output logic      [7:0]  PORT_A_OE_O,
	input  wire logic [7:0]  PORT_B_I,
	output logic      [7:0]  PORT_B_O,
	output logic      [7:0]  PORT_B_OE_O,
	input  wire logic [7:0]  PORT_C_I,
	output logic      [7:0]  PORT_C_O,
	output logic      [7:0]  PORT_C_OE_O
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [31:0] sync1_q;
	logic [31:0] sync2_q;

	always_ff @(posedge SYS_CLK_I) begin
		sync1_q <= {DMA_PENDING_FLAG_I, TIMER_PENDING_FLAG_I, DIGITAL_IO_PENDING_FLAG_I,
			ANALOG_PENDING_FLAG_I, CURRENT_ANALOG_CHANNEL_I, PORT_A_I, PORT_B_I, PORT_C_I};
		sync2_q <= sync1_q;
	end

	dcd_byte_t status_s;
	dcd_byte_t pa_in;
	dcd_byte_t pb_in;
	dcd_byte_t pc_in;
	assign status_s = sync2_q[31:24];
	assign pa_in    = sync2_q[23:16];
	assign pb_in    = sync2_q[15:8];
	assign pc_in    = sync2_q[7:0];

	// ****************************************
	// apb decode
	// ****************************************
	// byte offset n sits at byte address 4*n; one-cycle access phase
	function automatic logic [5:0] word_ix(input logic [7:0] a);
		return a[7:2];
	endfunction : word_ix

	logic       acc;
	logic       wr;
	logic [5:0] ix;
	dcd_byte_t  wb;
	logic       known;
	assign acc = PSEL_I && PENABLE_I;
	assign ix  = word_ix(PADDR_I);
	// byte lane 0 carries the 8-bit registers
	assign wr  = acc && PWRITE_I && PSTRB_I[0] && known && (PADDR_I[1:0] == 2'b00);
	assign wb  = PWDATA_I[7:0];

	always_comb begin
		unique case (ix)
			6'(`DCD_OFS_STATUS), 6'(`DCD_OFS_PORT_A), 6'(`DCD_OFS_PORT_B),
			6'(`DCD_OFS_PORT_C), 6'(`DCD_OFS_DIO_CTL), 6'(`DCD_OFS_CNT_LO),
			6'(`DCD_OFS_CNT_MID), 6'(`DCD_OFS_CNT_HI), 6'(`DCD_OFS_CMD),
			6'(`DCD_OFS_REV), 6'(`DCD_OFS_CNT_CTL): known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// ****************************************
	// software registers
	// ****************************************
	dcd_byte_t pa_q;
	dcd_byte_t pb_q;
	dcd_byte_t pc_q;
	dcd_byte_t dio_ctl_q;
	dcd_byte_t cnt_ctl_q;
	dcd_byte_t stage_lo_q;
	dcd_byte_t stage_mid_q;
	dcd_byte_t stage_hi_q;

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			pa_q <= 8'h00;
			pb_q <= 8'h00;
			pc_q <= 8'h00;
		end else if (wr) begin
			if (ix == 6'(`DCD_OFS_PORT_A)) pa_q <= wb;
			if (ix == 6'(`DCD_OFS_PORT_B)) pb_q <= wb;
			if (ix == 6'(`DCD_OFS_PORT_C)) pc_q <= wb;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			dio_ctl_q <= `DCD_DIO_CTL_RST;
		end else if (wr && ix == 6'(`DCD_OFS_DIO_CTL)) begin
			dio_ctl_q <= wb;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			cnt_ctl_q <= 8'h00;
		end else if (wr && ix == 6'(`DCD_OFS_CNT_CTL)) begin
			cnt_ctl_q <= wb;
		end
	end

	// each staging byte stands alone, so write order is free
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			stage_lo_q  <= 8'h00;
			stage_mid_q <= 8'h00;
			stage_hi_q  <= 8'h00;
		end else if (wr) begin
			if (ix == 6'(`DCD_OFS_CNT_LO))  stage_lo_q  <= wb;
			if (ix == 6'(`DCD_OFS_CNT_MID)) stage_mid_q <= wb;
			if (ix == 6'(`DCD_OFS_CNT_HI))  stage_hi_q  <= wb;
		end
	end

	// ****************************************
	// command decode
	// ****************************************
	logic      cmd_wr;
	logic      sel;
	logic [1:0] tgt;
	assign cmd_wr = wr && ix == 6'(`DCD_OFS_CMD);
	assign sel    = wb[`DCD_BIT_SEL];
	assign tgt    = {cmd_wr && sel, cmd_wr && !sel};

	// a command byte acts on each set op bit, except zero when load is set and a disable when its enable is set
	function automatic logic [1:0] op(input logic [1:0] t, input dcd_byte_t b,
		input int unsigned bitn);
		return t & {2{b[bitn]}};
	endfunction : op

	logic [1:0] do_latch;
	logic [1:0] do_gdis;
	logic [1:0] do_gen;
	logic [1:0] do_cdis;
	logic [1:0] do_cen;
	logic [1:0] do_load;
	logic [1:0] do_zero;
	assign do_latch = op(tgt, wb, `DCD_BIT_LATCH);
	assign do_gdis  = op(tgt, wb, `DCD_BIT_GT_DIS);
	assign do_gen   = op(tgt, wb, `DCD_BIT_GT_EN);
	assign do_cdis  = op(tgt, wb, `DCD_BIT_CT_DIS);
	assign do_cen   = op(tgt, wb, `DCD_BIT_CT_EN);
	assign do_load  = op(tgt, wb, `DCD_BIT_LOAD);
	assign do_zero  = op(tgt, wb, `DCD_BIT_ZERO);

	// ****************************************
	// clock sources
	// ****************************************
	logic     en_10m;
	logic     en_1m;
	logic     en_100k;
	logic     ext_clk_d1_q;
	logic     ext_tick;
	logic     tick0;
	logic     tick1;
	dcd_src_e c1_src;

	dcd_rate_gen u_rate (
		.clk_i     (SYS_CLK_I),
		.rst_i     (SRST_I),
		.en_10m_o  (en_10m),
		.en_1m_o   (en_1m),
		.en_100k_o (en_100k)
	);

	logic pin_sel;
	assign pin_sel = dio_ctl_q[`DCD_BIT_PIN_SEL];

	// rising edge of clock 1 pin, taken after the synchroniser
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			ext_clk_d1_q <= 1'b0;
		end else begin
			ext_clk_d1_q <= pc_in[6];
		end
	end
	assign ext_tick = !pin_sel && pc_in[6] && !ext_clk_d1_q;

	assign tick0  = cnt_ctl_q[`DCD_BIT_C0_RATE] ? en_1m : en_10m;
	assign c1_src = cnt_ctl_q[`DCD_BIT_C1_SRC] ? DCD_SRC_EXT : DCD_SRC_INT;
	assign tick1  = (c1_src == DCD_SRC_EXT) ? ext_tick :
		(cnt_ctl_q[`DCD_BIT_C1_RATE] ? en_100k : en_10m);

	// ****************************************
	// counters
	// ****************************************
	logic [23:0] cnt0;
	logic [15:0] cnt1;
	logic        out0;

	dcd_down_counter #(.W(24)) u_cnt0 (
		.clk_i      (SYS_CLK_I),
		.rst_i      (SRST_I),
		.tick_i     (tick0),
		.gate_i     (!pin_sel && pc_in[4]),
		.load_i     (do_load[0]),
		.load_val_i ({stage_hi_q, stage_mid_q, stage_lo_q}),
		.zero_i     (do_zero[0]),
		.ct_en_i    (do_cen[0]),
		.ct_dis_i   (do_cdis[0]),
		.gt_en_i    (do_gen[0]),
		.gt_dis_i   (do_gdis[0]),
		.count_o    (cnt0),
		.out_o      (out0)
	);

	dcd_down_counter #(.W(16)) u_cnt1 (
		.clk_i      (SYS_CLK_I),
		.rst_i      (SRST_I),
		.tick_i     (tick1),
		.gate_i     (!pin_sel && pc_in[5]),
		.load_i     (do_load[1]),
		.load_val_i ({stage_mid_q, stage_lo_q}),
		.zero_i     (do_zero[1]),
		.ct_en_i    (do_cen[1]),
		.ct_dis_i   (do_cdis[1]),
		.gt_en_i    (do_gen[1]),
		.gt_dis_i   (do_gdis[1]),
		.count_o    (cnt1),
		.out_o      ()
	);

	// ****************************************
	// latch readback
	// ****************************************
	dcd_cnt_t latched_q;

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			latched_q <= 24'h000000;
		end else if (do_latch[0]) begin
			latched_q <= cnt0;
		end else if (do_latch[1]) begin
			latched_q[15:0] <= cnt1;
		end
	end

	// out 0 is stretched so the pulse survives slow external sampling
	logic out0_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			out0_q <= 1'b0;
		end else if (out0) begin
			out0_q <= 1'b1;
		end else if (tick0) begin
			out0_q <= 1'b0;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			PORT_A_OE_O <= 8'h00;
			PORT_B_OE_O <= 8'h00;
			PORT_C_OE_O <= 8'h00;
		end else begin
			PORT_A_OE_O      <= {8{!dio_ctl_q[`DCD_BIT_DIR_A]}};
			PORT_B_OE_O      <= {8{!dio_ctl_q[`DCD_BIT_DIR_B]}};
			PORT_C_OE_O[3:0] <= {4{!dio_ctl_q[`DCD_BIT_DIR_CL]}};
			if (pin_sel) begin
				PORT_C_OE_O[7:4] <= {4{!dio_ctl_q[`DCD_BIT_DIR_CH]}};
			end else begin
				PORT_C_OE_O[7:4] <= 4'h8;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			PORT_A_O <= 8'h00;
			PORT_B_O <= 8'h00;
			PORT_C_O <= 8'h00;
		end else begin
			PORT_A_O <= pa_q;
			PORT_B_O <= pb_q;
			PORT_C_O <= pin_sel ? pc_q : {out0_q, pc_q[6:0]};
		end
	end

	// ****************************************
	// apb read and answer
	// ****************************************
	dcd_byte_t rd;
	always_comb begin
		rd = 8'h00;
		unique case (ix)
			6'(`DCD_OFS_STATUS):  rd = status_s;
			6'(`DCD_OFS_PORT_A):  rd = pa_in;
			6'(`DCD_OFS_PORT_B):  rd = pb_in;
			6'(`DCD_OFS_PORT_C):  rd = pc_in;
			6'(`DCD_OFS_DIO_CTL): rd = dio_ctl_q;
			6'(`DCD_OFS_CNT_LO):  rd = latched_q[7:0];
			6'(`DCD_OFS_CNT_MID): rd = latched_q[15:8];
			6'(`DCD_OFS_CNT_HI):  rd = latched_q[23:16];
			6'(`DCD_OFS_REV):     rd = REVISION;
			6'(`DCD_OFS_CNT_CTL): rd = cnt_ctl_q;
			default:              rd = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h00000000;
		end else if (PSEL_I && !PENABLE_I) begin
			PREADY_O  <= 1'b1;
			PSLVERR_O <= !known || (PADDR_I[1:0] != 2'b00);
			PRDATA_O  <= PWRITE_I ? 32'h00000000 : {24'h000000, rd};
		end else begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end
endmodule : dcd_top

// ===== verif/dcd_top_chk.sv
// assertion checker for the counter / digital io / status block
// assumes: bound into dcd_top, sees only its ports, one clock domain
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_top_chk
	import dcd_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h13
)(
	input wire logic        SYS_CLK_I,
	input wire logic        SRST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0]  PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        DMA_PENDING_FLAG_I,
	input wire logic        TIMER_PENDING_FLAG_I,
	input wire logic        DIGITAL_IO_PENDING_FLAG_I,
	input wire logic        ANALOG_PENDING_FLAG_I,
	input wire logic [3:0]  CURRENT_ANALOG_CHANNEL_I,
	input wire logic [7:0]  PORT_A_O,
	input wire logic [7:0]  PORT_A_OE_O,
	input wire logic [7:0]  PORT_B_OE_O,
	input wire logic [7:0]  PORT_C_OE_O
);
	// ************************************************************
	// shadows of written registers
	// ************************************************************
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SRST_I);
	logic [5:0] idx;
	logic       wr_hit;
	logic       rd_hit;
	logic       bad;
	dcd_byte_t  stat;
	dcd_byte_t  dio_q;
	dcd_byte_t  pa_q;
	assign idx    = PADDR_I[7:2];
	assign bad    = idx < 6'(`DCD_OFS_STATUS) || idx > 6'(`DCD_OFS_CNT_CTL) || PADDR_I[1:0] != 2'b00;
	assign wr_hit = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && !bad;
	assign rd_hit = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && !bad;
	assign stat   = {DMA_PENDING_FLAG_I, TIMER_PENDING_FLAG_I, DIGITAL_IO_PENDING_FLAG_I,
		ANALOG_PENDING_FLAG_I, CURRENT_ANALOG_CHANNEL_I};
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			dio_q <= `DCD_DIO_CTL_RST;
		end else if (wr_hit && idx == 6'(`DCD_OFS_DIO_CTL)) begin
			dio_q <= PWDATA_I[7:0];
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			pa_q <= 8'h00;
		end else if (wr_hit && idx == 6'(`DCD_OFS_PORT_A)) begin
			pa_q <= PWDATA_I[7:0];
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	chk_ready_access: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
		else $error("ready missing in access phase");
	chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held beyond one cycle");
	chk_map_error: assert property (PREADY_O |-> PSLVERR_O == bad)
		else $error("error response does not match address");
	// pins are held steady by the bench well beyond the synchroniser depth
	chk_status_byte: assert property (rd_hit && idx == 6'(`DCD_OFS_STATUS) |->
		PRDATA_O == {24'h0, $past(stat, 6)})
		else $error("status byte wrong");
	chk_rev_value: assert property (rd_hit && idx == 6'(`DCD_OFS_REV) |->
		PRDATA_O == {24'h0, REVISION})
		else $error("revision byte wrong");
	chk_cmd_reads_zero: assert property (rd_hit && idx == 6'(`DCD_OFS_CMD) |->
		PRDATA_O == 32'h0)
		else $error("command register not write only");
	chk_dir_ab: assert property (wr_hit && idx == 6'(`DCD_OFS_DIO_CTL) |-> ##2
		PORT_A_OE_O == {8{~dio_q[4]}} && PORT_B_OE_O == {8{~dio_q[1]}})
		else $error("port a or b direction wrong");
	chk_dir_c: assert property (wr_hit && idx == 6'(`DCD_OFS_DIO_CTL) |-> ##2
		PORT_C_OE_O == {dio_q[7] ? {4{~dio_q[3]}} : 4'h8, {4{~dio_q[0]}}})
		else $error("port c direction wrong");
	chk_port_a_drive: assert property (wr_hit && idx == 6'(`DCD_OFS_PORT_A) |->
		##2 PORT_A_O == pa_q)
		else $error("port a drive value wrong");
	chk_reset_inputs: assert property ($past(SRST_I) |->
		PORT_A_OE_O == 8'h00 && PORT_B_OE_O == 8'h00 && PORT_C_OE_O == 8'h00)
		else $error("pins driven after reset");
endmodule : dcd_top_chk

bind dcd_top dcd_top_chk #(.REVISION(REVISION)) u_chk (
	.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.DMA_PENDING_FLAG_I(DMA_PENDING_FLAG_I), .TIMER_PENDING_FLAG_I(TIMER_PENDING_FLAG_I),
	.DIGITAL_IO_PENDING_FLAG_I(DIGITAL_IO_PENDING_FLAG_I),
	.ANALOG_PENDING_FLAG_I(ANALOG_PENDING_FLAG_I),
	.CURRENT_ANALOG_CHANNEL_I(CURRENT_ANALOG_CHANNEL_I), .PORT_A_O(PORT_A_O),
	.PORT_A_OE_O(PORT_A_OE_O), .PORT_B_OE_O(PORT_B_OE_O), .PORT_C_OE_O(PORT_C_OE_O)
);

// ===== verif/dcd_top_tb.sv
// self-checking bench for the counter / digital io / status block
// assumes: checker bound separately; the bench is apb master and outside world
`timescale 1ns/1ps
`include "dcd_cfg.svh"
`define DCD_CMP(g, e) cmp(32'(g), 32'(e))
module dcd_top_tb
	import dcd_pkg::*;
;
	localparam logic [7:0] REV_CODE = 8'h31; // arbitrary value
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, last_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	dcd_byte_t   stat_v, ext_a, ext_b, ext_c, rd;
	dcd_byte_t   a_o, a_oe, b_o, b_oe, c_o, c_oe, pin_a, pin_b, pin_c;
	dcd_byte_t   dirs [5] = '{8'h80, 8'h00, 8'h88, 8'h13, 8'h9B};
	int          n_mismatch, total_checks, wait_n;
	// undriven lines follow the outside world, driven ones loop back
	assign pin_a = (a_oe & a_o) | (~a_oe & ext_a);
	assign pin_b = (b_oe & b_o) | (~b_oe & ext_b);
	assign pin_c = (c_oe & c_o) | (~c_oe & ext_c);
	dcd_top #(.REVISION(REV_CODE)) u_dut (
		.SYS_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.DMA_PENDING_FLAG_I(stat_v[7]), .TIMER_PENDING_FLAG_I(stat_v[6]),
		.DIGITAL_IO_PENDING_FLAG_I(stat_v[5]), .ANALOG_PENDING_FLAG_I(stat_v[4]),
		.CURRENT_ANALOG_CHANNEL_I(stat_v[3:0]),
		.PORT_A_I(pin_a), .PORT_A_O(a_o), .PORT_A_OE_O(a_oe),
		.PORT_B_I(pin_b), .PORT_B_O(b_o), .PORT_B_OE_O(b_oe),
		.PORT_C_I(pin_c), .PORT_C_O(c_o), .PORT_C_OE_O(c_oe)
	);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ************************************************************
	// bus tasks
	// ************************************************************
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask : cmp
	task automatic give_verdict();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic apb(input logic w, input logic [5:0] idx, input dcd_byte_t d,
		output dcd_byte_t r);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_mismatch++;
			$display("wrong value at %0t: no ready", $time);
		end
		r = prdata[7:0];
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [5:0] idx, input dcd_byte_t d);
		dcd_byte_t x;
		apb(1'b1, idx, d, x);
	endtask : wr
	task automatic rdc(input logic [5:0] idx, input dcd_byte_t e);
		dcd_byte_t x;
		// pin inputs pass a synchroniser first
		repeat (4) @(posedge clk);
		apb(1'b0, idx, 8'h00, x);
		`DCD_CMP(x, e);
	endtask : rdc
	task automatic cmd(input dcd_byte_t c);
		wr(`DCD_OFS_CMD, c);
	endtask : cmd
	task automatic rd3(input dcd_byte_t lo, input dcd_byte_t mid, input dcd_byte_t hi);
		rdc(`DCD_OFS_CNT_LO, lo);
		rdc(`DCD_OFS_CNT_MID, mid);
		rdc(`DCD_OFS_CNT_HI, hi);
	endtask : rd3
	// tick phase is unknown, so counts are judged within a window
	task automatic burst(input dcd_byte_t sel, input int cyc, input int pulses,
		input int lo_n, input int hi_n);
		logic [15:0] v;
		wr(`DCD_OFS_CNT_LO, 8'h00);
		wr(`DCD_OFS_CNT_MID, 8'h01);
		cmd(sel | 8'h02);
		cmd(sel | 8'h04);
		repeat (cyc) @(posedge clk);
		for (int i = 0; i < pulses; i++) begin
			ext_c[6] <= 1'b1;
			repeat (4) @(posedge clk);
			ext_c[6] <= 1'b0;
			repeat (4) @(posedge clk);
		end
		cmd(sel | 8'h08);
		cmd(sel | 8'h40);
		apb(1'b0, `DCD_OFS_CNT_LO, 8'h00, v[7:0]);
		apb(1'b0, `DCD_OFS_CNT_MID, 8'h00, v[15:8]);
		`DCD_CMP(v >= 16'h0100 - hi_n && v <= 16'h0100 - lo_n, 1'b1);
		repeat (200) @(posedge clk);
		cmd(sel | 8'h40);
		rdc(`DCD_OFS_CNT_LO, v[7:0]);
	endtask : burst
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{srst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 8'h00, 32'h0, 4'hF};
		{stat_v, ext_a, ext_b, ext_c, rd} = {8'hB9, 8'hC3, 8'h3C, 8'h00, 8'h00};
		{n_mismatch, total_checks, last_err} = '0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rdc(`DCD_OFS_DIO_CTL, `DCD_DIO_CTL_RST);
		`DCD_CMP(c_oe, 8'h00);
		rdc(`DCD_OFS_STATUS, 8'hB9);
		stat_v <= 8'h46;
		rdc(`DCD_OFS_STATUS, 8'h46);
		rdc(`DCD_OFS_REV, REV_CODE);
		rdc(`DCD_OFS_CMD, 8'h00);
		apb(1'b0, 6'h00, 8'h00, rd);
		`DCD_CMP(last_err, 1'b1);
		apb(1'b1, 6'h12, 8'h55, rd);
		`DCD_CMP(last_err, 1'b1);
		foreach (dirs[i]) begin
			wr(`DCD_OFS_DIO_CTL, dirs[i]);
			repeat (3) @(posedge clk);
			`DCD_CMP(a_oe, {8{~dirs[i][4]}});
			`DCD_CMP(b_oe, {8{~dirs[i][1]}});
			`DCD_CMP(c_oe, {dirs[i][7] ? {4{~dirs[i][3]}} : 4'h8, {4{~dirs[i][0]}}});
		end
		wr(`DCD_OFS_DIO_CTL, 8'h80);
		wr(`DCD_OFS_PORT_A, 8'hA5);
		wr(`DCD_OFS_PORT_B, 8'h5A);
		wr(`DCD_OFS_PORT_C, 8'h3C);
		pstrb <= 4'hE;
		wr(`DCD_OFS_PORT_A, 8'hFF);
		pstrb <= 4'hF;
		rdc(`DCD_OFS_PORT_A, 8'hA5);
		rdc(`DCD_OFS_PORT_B, 8'h5A);
		rdc(`DCD_OFS_PORT_C, 8'h3C);
		wr(`DCD_OFS_DIO_CTL, 8'h9B);
		rdc(`DCD_OFS_PORT_A, 8'hC3);
		rdc(`DCD_OFS_PORT_B, 8'h3C);
		wr(`DCD_OFS_CNT_HI, 8'h12);
		wr(`DCD_OFS_CNT_MID, 8'h34);
		wr(`DCD_OFS_CNT_LO, 8'h56);
		cmd(8'h40);
		rd3(8'h00, 8'h00, 8'h00);
		cmd(8'h02);
		rdc(`DCD_OFS_CNT_HI, 8'h00);
		cmd(8'h40);
		rd3(8'h56, 8'h34, 8'h12);
		wr(`DCD_OFS_CNT_HI, 8'hEF);
		wr(`DCD_OFS_CNT_MID, 8'hCD);
		wr(`DCD_OFS_CNT_LO, 8'hAB);
		cmd(8'h82);
		cmd(8'hC0);
		rd3(8'hAB, 8'hCD, 8'h12);
		cmd(8'h01);
		cmd(8'h40);
		rd3(8'h00, 8'h00, 8'h00);
		cmd(8'hC0);
		rdc(`DCD_OFS_CNT_MID, 8'hCD);
		wr(`DCD_OFS_CNT_HI, 8'h00);
		burst(8'h00, 400, 0, 19, 21);
		wr(`DCD_OFS_CNT_CTL, 8'h20);
		burst(8'h00, 400, 0, 1, 3);
		wr(`DCD_OFS_CNT_CTL, 8'h00);
		burst(8'h80, 400, 0, 19, 21);
		wr(`DCD_OFS_CNT_CTL, 8'h40);
		burst(8'h80, 4100, 0, 1, 3);
		wr(`DCD_OFS_CNT_CTL, 8'h00);
		wr(`DCD_OFS_DIO_CTL, 8'h00);
		cmd(8'h90);
		burst(8'h80, 400, 0, 0, 0);
		ext_c[5] <= 1'b1;
		burst(8'h80, 400, 0, 19, 21);
		cmd(8'hA0);
		ext_c[5] <= 1'b0;
		burst(8'h80, 400, 0, 19, 21);
		wr(`DCD_OFS_CNT_CTL, 8'h80);
		burst(8'h80, 20, 5, 5, 5);
		// counter 0 reaching zero must show on c7 while pin select is 0
		`DCD_CMP(c_o[7], 1'b0);
		wr(`DCD_OFS_CNT_LO, 8'h02);
		wr(`DCD_OFS_CNT_MID, 8'h00);
		cmd(8'h02);
		cmd(8'h04);
		for (wait_n = 0; wait_n < 100 && c_o[7] !== 1'b1; wait_n++) begin
			@(posedge clk);
		end
		`DCD_CMP(c_o[7], 1'b1);
		cmd(8'h08);
		give_verdict();
	end
endmodule : dcd_top_tb
